/* File: hw/beam_eval.sv */
// beam evaluation: monitored blanking, reduced resolution, optical sync
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "beam_eval_regs.svh"

module beam_eval
	import beam_eval_pkg::*;
(
	input  wire logic        CLK_IN,
	input  wire logic        RST_B_IN,
	input  wire logic        CE_IN,
	input  wire logic [31:0] BEAMS_BLOCKED_IN,
	input  wire logic        SCAN_DONE_IN,
	input  wire logic        START_IN,
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [31:0] RDATA_OUT,
	input  wire logic        NV_VALID_IN,
	input  wire logic [31:0] NV_AREA_IN,
	input  wire logic [5:0]  NV_SIZE_IN,
	output logic             NV_WRITE_OUT,
	output logic             NV_VALID_OUT,
	output logic      [31:0] NV_AREA_OUT,
	output logic      [5:0]  NV_SIZE_OUT,
	output logic             SAFETY_OUTPUT_PAIR_OUT,
	output logic             INTERLOCK_OUT,
	output logic             BLANK_ACTIVE_OUT,
	output logic             SYNC_OUT,
	output logic      [31:0] BEAM_INDICATOR_LAMP_OUT
);
	localparam int N = `BEAM_COUNT;
	localparam int W = `RUN_W;

	// 6 for 12..16 beams, one more per doubling, 10 up to 256
	function automatic logic [W-1:0] sync_need(input int beams);
		if (beams <= 16) begin
			sync_need = 6'h06;
		end else if (beams <= 32) begin
			sync_need = 6'h07;
		end else if (beams <= 64) begin
			sync_need = 6'h08;
		end else if (beams <= 128) begin
			sync_need = 6'h09;
		end else begin
			sync_need = 6'h0A;
		end
	endfunction
	localparam logic [W-1:0] SYNC_REQ = sync_need(N);

	// ==========================================================
	// state
	run_state_t   st_q;
	teach_state_t te_q;
	logic [7:0]   ctrl_q;
	logic         mb_en_q;
	logic         rr_en_q;
	logic [N-1:0] area_q;
	logic [W-1:0] size_q;
	logic [N-1:0] blk_q;
	logic         sync_q;
	logic         need_start_q;
	logic         load_q;
	logic         cfg_err_q;
	logic         teach_err_q;
	logic         nv_wr_q;
	logic [N-1:0] lamp_q;
	logic [31:0]  rdata_q;

	// ==========================================================
	// per-beam run lengths, area checks
	logic [W-1:0] blk_run [0:N];
	logic [W-1:0] clr_run [0:N];
	logic [W-1:0] free_run [0:N];
	logic [W-1:0] blk_cnt [0:N];
	logic [W-1:0] flex_clr [0:N];
	logic         area_hit [0:N];
	logic [N:0]   blk_pad;
	logic [N:0]   area_pad;
	logic [N-1:0] bad_out;
	logic [N-1:0] bad_len;
	logic [N-1:0] bad_miss;
	logic [N-1:0] rr_bad;
	logic [N-1:0] sync_first;
	logic [N-1:0] sync_any;
	logic [N-1:0] free_first;
	logic [W-1:0] size_lo;
	logic [W-1:0] size_hi;
	logic [W-1:0] rr_n;

	assign blk_pad  = {1'b0, BEAMS_BLOCKED_IN};
	assign area_pad = {1'b0, area_q};
	assign size_lo  = (size_q == 6'h01) ? 6'h01 : size_q - 6'h01;
	assign size_hi  = size_q + 6'h01;
	assign rr_n     = {4'h0, ctrl_q[`CTRL_RRN_LSB +: 2]};
	assign blk_run[0]  = 6'h00;
	assign clr_run[0]  = 6'h00;
	assign free_run[0] = 6'h00;
	assign blk_cnt[0]  = 6'h00;
	assign flex_clr[0] = 6'h00;
	assign area_hit[0] = 1'b0;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : beam_g
			wire logic b      = BEAMS_BLOCKED_IN[g];
			wire logic a      = area_q[g];
			wire logic in_seg = (g < `SEG_BEAMS);
			wire logic r_end  = b & ~blk_pad[g+1];
			assign blk_run[g+1]  = b ? blk_run[g] + 6'h01 : 6'h00;
			assign clr_run[g+1]  = b ? 6'h00 : clr_run[g] + 6'h01;
			assign free_run[g+1] = a ? 6'h00 : free_run[g] + 6'h01;
			assign blk_cnt[g+1]  = blk_cnt[g] + {5'h00, b};
			assign flex_clr[g+1] = flex_clr[g] + {5'h00, ~in_seg & ~a};
			// each separate area needs its own object somewhere inside
			assign area_hit[g+1] = a & (b | area_hit[g]);
			assign bad_out[g]  = b & ~a;
			// edge tolerance is applied to the run, interior beams fixed
			assign bad_len[g]  = r_end & ((blk_run[g+1] < size_lo) |
				(blk_run[g+1] > size_hi));
			assign bad_miss[g] = a & ~area_pad[g+1] & ~area_hit[g+1];
			assign rr_bad[g]   = r_end & (blk_run[g+1] > rr_n);
			assign sync_first[g] = in_seg & (clr_run[g+1] >= SYNC_REQ);
			assign sync_any[g]   = clr_run[g+1] >= SYNC_REQ;
			assign free_first[g] = in_seg & (free_run[g+1] >= SYNC_REQ);
		end
	endgenerate

	// ==========================================================
	// scan verdict
	wire logic       mb_ok   = ~|bad_out & ~|bad_len & ~|bad_miss;
	wire logic       rr_ok   = ~|rr_bad;
	wire logic       sync_d  = sync_q ? |sync_any : |sync_first;
	wire logic       pat_ok  = mb_en_q ? mb_ok : rr_en_q ? rr_ok : ~|BEAMS_BLOCKED_IN;
	wire logic       scan_ok = sync_d & pat_ok;
	wire logic [W-1:0] obj_sz = blk_cnt[N];
	wire logic       fit_ok  = |free_first & (flex_clr[N] >= 6'h02);
	wire logic [1:0] mode    = ctrl_q[`CTRL_MODE_LSB +: 2];
	wire logic [N-1:0] tolerated = mb_en_q ? area_q : (rr_en_q & rr_ok) ? {N{1'b1}} : '0;

	// ==========================================================
	// register port decode
	wire logic wr_ctrl = CE_IN & WR_IN & (ADDR_IN == `OFS_CTRL);
	wire logic wr_cmd  = CE_IN & WR_IN & (ADDR_IN == `OFS_CMD);
	wire logic [2:0] cmd = WDATA_IN[2:0];
	wire logic req_mb  = WDATA_IN[`CTRL_MB_BIT];
	wire logic req_rr  = WDATA_IN[`CTRL_RR_BIT];
	wire logic req_fix = WDATA_IN[`CTRL_FIX_BIT];
	wire logic req_flt = WDATA_IN[`CTRL_FLT_BIT];
	wire logic [1:0] req_n = WDATA_IN[`CTRL_RRN_LSB +: 2];
	// forbidden mixes and a zero beam count are refused whole
	wire logic cfg_bad = (req_mb & (req_rr | req_fix)) |
		(req_rr & (req_fix | req_flt)) | (req_rr & (req_n == 2'h0));
	wire logic cfg_take = wr_ctrl & ~cfg_bad;
	wire logic mb_off   = cfg_take & ~req_mb & mb_en_q;
	wire logic cmd_rst  = wr_cmd & (cmd == `CMD_RESTART);
	wire logic fin_ok   = wr_cmd & (cmd == `CMD_FINISH) & (te_q == TE_DONE) & fit_ok;
	wire logic restart  = cmd_rst | fin_ok;
	wire logic scan_ev  = CE_IN & SCAN_DONE_IN;

	logic [31:0] rd_mux;
	assign rd_mux = (ADDR_IN == `OFS_CTRL)   ? {24'h000000, ctrl_q} :
			(ADDR_IN == `OFS_STATUS) ? {20'h00000, cfg_err_q, teach_err_q, te_q,
				need_start_q, rr_en_q, mb_en_q, sync_q, st_q, 2'h0} :
			(ADDR_IN == `OFS_AREA)   ? area_q :
			(ADDR_IN == `OFS_CMD)    ? {26'h0000000, size_q} : 32'h00000000;

	// ==========================================================
	// configuration and non-volatile pattern
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			ctrl_q    <= `CTRL_RESET;
			rr_en_q   <= 1'b0;
			cfg_err_q <= 1'b0;
			load_q    <= 1'b1;
		end else if (CE_IN) begin
			if (wr_ctrl) begin
				cfg_err_q <= cfg_bad;
			end
			if (cfg_take) begin
				ctrl_q  <= WDATA_IN[7:0];
				rr_en_q <= req_rr;
			end
			load_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			mb_en_q <= 1'b0;
			area_q  <= '0;
			size_q  <= 6'h00;
			nv_wr_q <= 1'b0;
		end else if (CE_IN) begin
			nv_wr_q <= mb_off | fin_ok;
			if (load_q) begin
				// stored pattern taken once, right after reset release
				mb_en_q <= NV_VALID_IN;
				area_q  <= NV_VALID_IN ? NV_AREA_IN : '0;
				size_q  <= NV_VALID_IN ? NV_SIZE_IN : 6'h00;
			end else if (mb_off) begin
				mb_en_q <= 1'b0;
				area_q  <= '0;
				size_q  <= 6'h00;
			end else if (wr_cmd & (cmd == `CMD_BEGIN) & (te_q == TE_ARMED) &
					|blk_q) begin
				area_q <= blk_q;
				size_q <= 6'h00;
			end else if (scan_ev & (te_q == TE_RECORD)) begin
				area_q <= area_q | BEAMS_BLOCKED_IN;
				if (size_q == 6'h00) begin
					size_q <= obj_sz;
				end
			end else if (fin_ok) begin
				mb_en_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// teaching sequence
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			te_q        <= TE_IDLE;
			teach_err_q <= 1'b0;
		end else if (CE_IN) begin
			case (te_q)
				TE_IDLE: begin
					if (cfg_take & req_mb & ~mb_en_q) begin
						te_q        <= TE_ARMED;
						teach_err_q <= 1'b0;
					end
				end
				TE_ARMED: begin
					if (wr_cmd & (cmd == `CMD_BEGIN)) begin
						te_q        <= |blk_q ? TE_RECORD : TE_ARMED;
						teach_err_q <= ~|blk_q;
					end
				end
				TE_RECORD: begin
					if (scan_ev & (size_q != 6'h00) & (obj_sz != size_q)) begin
						te_q        <= TE_ARMED;
						teach_err_q <= 1'b1;
					end else if (wr_cmd & (cmd == `CMD_END)) begin
						te_q <= TE_DONE;
					end
				end
				TE_DONE: begin
					if (wr_cmd & (cmd == `CMD_FINISH)) begin
						te_q        <= fit_ok ? TE_IDLE : TE_ARMED;
						teach_err_q <= ~fit_ok;
					end
				end
				default: begin
					te_q <= TE_IDLE;
				end
			endcase
			if (mb_off | (cfg_take & ~req_mb)) begin
				te_q <= TE_IDLE;
			end
		end
	end

	// ==========================================================
	// run, stop and interlock
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			st_q         <= ST_STOP;
			sync_q       <= 1'b0;
			need_start_q <= 1'b1;
			lamp_q       <= '0;
		end else if (CE_IN) begin
			if (restart) begin
				st_q         <= ST_STOP;
				need_start_q <= 1'b1;
			end else if (scan_ev) begin
				sync_q <= sync_d;
				lamp_q <= ~sync_d ? `ALT_LAMPS :
					(BEAMS_BLOCKED_IN & ~tolerated);
				case (st_q)
					ST_STOP: begin
						// mode applies alike with or without blanking
						if (scan_ok & (te_q == TE_IDLE)) begin
							st_q <= (mode == `MODE_SRI) |
								(need_start_q & (mode != `MODE_AUTO)) ?
								ST_INTERLOCK : ST_RUN;
						end
					end
					ST_INTERLOCK: begin
						// a pattern mismatch must not wait for start to be caught
						if (~scan_ok) begin
							st_q <= ST_STOP;
						end
					end
					ST_RUN: begin
						if (~scan_ok) begin
							st_q <= ST_STOP;
						end
					end
					default: begin
						st_q <= ST_STOP;
					end
				endcase
			end else if ((st_q == ST_INTERLOCK) & START_IN & sync_q) begin
				st_q         <= ST_RUN;
				need_start_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			blk_q   <= '0;
			rdata_q <= 32'h00000000;
		end else if (CE_IN) begin
			if (SCAN_DONE_IN) begin
				blk_q <= BEAMS_BLOCKED_IN;
			end
			rdata_q <= RD_IN ? rd_mux : 32'h00000000;
		end
	end

	// ==========================================================
	// outputs
	assign RDATA_OUT               = rdata_q;
	assign NV_WRITE_OUT            = nv_wr_q;
	assign NV_VALID_OUT            = mb_en_q;
	assign NV_AREA_OUT             = area_q;
	assign NV_SIZE_OUT             = size_q;
	assign SAFETY_OUTPUT_PAIR_OUT  = (st_q == ST_RUN);
	assign INTERLOCK_OUT           = (st_q == ST_INTERLOCK);
	assign BLANK_ACTIVE_OUT        = (mb_en_q | rr_en_q) & (st_q != ST_STOP);
	assign SYNC_OUT                = sync_q;
	assign BEAM_INDICATOR_LAMP_OUT = lamp_q;
endmodule

/* File: hw/beam_eval_pkg.sv */
// types of the beam evaluation block
package beam_eval_pkg;
	typedef enum logic [1:0] {
		ST_STOP,
		ST_INTERLOCK,
		ST_RUN
	} run_state_t;

	typedef enum logic [1:0] {
		TE_IDLE,
		TE_ARMED,
		TE_RECORD,
		TE_DONE
	} teach_state_t;
endpackage

/* File: hw/beam_eval_regs.svh */
// constants of the beam evaluation block: offsets, fields, reset values, counts
`ifndef BEAM_EVAL_REGS_SVH
`define BEAM_EVAL_REGS_SVH

// ==========================================================
// geometry
`define BEAM_COUNT    32
`define SEG_BEAMS     16
`define RUN_W         6
`define ALT_LAMPS     32'h55555555

// ==========================================================
// register offsets
`define OFS_CTRL      4'h0
`define OFS_CMD       4'h4
`define OFS_STATUS    4'h8
`define OFS_AREA      4'hC

// ==========================================================
// control fields
`define CTRL_MB_BIT   0
`define CTRL_RR_BIT   1
`define CTRL_RRN_LSB  2
`define CTRL_MODE_LSB 4
`define CTRL_FLT_BIT  6
`define CTRL_FIX_BIT  7
`define CTRL_RESET    8'h00

// ==========================================================
// teach and restart commands
`define CMD_BEGIN     3'h1
`define CMD_END       3'h2
`define CMD_FINISH    3'h3
`define CMD_RESTART   3'h4

// ==========================================================
// start modes
`define MODE_AUTO     2'h0
`define MODE_SRI      2'h3

`endif

/* File: verif/beam_eval_sva.sv */
// port checker of the beam evaluation block
`timescale 1ns/100ps

module beam_eval_chk (
	input wire logic        CLK_IN,
	input wire logic        RST_B_IN,
	input wire logic        CE_IN,
	input wire logic [31:0] BEAMS_BLOCKED_IN,
	input wire logic        SCAN_DONE_IN,
	input wire logic        START_IN,
	input wire logic        WR_IN,
	input wire logic        RD_IN,
	input wire logic [31:0] RDATA_OUT,
	input wire logic        NV_WRITE_OUT,
	input wire logic        SAFETY_OUTPUT_PAIR_OUT,
	input wire logic        INTERLOCK_OUT,
	input wire logic        BLANK_ACTIVE_OUT,
	input wire logic        SYNC_OUT,
	input wire logic [31:0] BEAM_INDICATOR_LAMP_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	// ==========================================
	// state and sync
	chk_run_synced: assert property (SAFETY_OUTPUT_PAIR_OUT |-> SYNC_OUT)
		else $error("run without sync");
	chk_one_state: assert property (!(SAFETY_OUTPUT_PAIR_OUT && INTERLOCK_OUT))
		else $error("run and interlock together");
	chk_blank_stop: assert property (BLANK_ACTIVE_OUT |-> SAFETY_OUTPUT_PAIR_OUT || INTERLOCK_OUT)
		else $error("blank lamp lit in stop");
	chk_unsync_lamps: assert property (CE_IN && SCAN_DONE_IN && !WR_IN ##1 !SYNC_OUT
		|-> BEAM_INDICATOR_LAMP_OUT == 32'h55555555) else $error("unsynced lamp pattern wrong");
	chk_clear_sync: assert property (CE_IN && SCAN_DONE_IN && !WR_IN
		&& BEAMS_BLOCKED_IN[15:0] == 16'h0000 |=> SYNC_OUT) else $error("clear scan gave no sync");
	chk_lost_sync: assert property (CE_IN && SCAN_DONE_IN && !WR_IN && &BEAMS_BLOCKED_IN
		|=> !SYNC_OUT && !SAFETY_OUTPUT_PAIR_OUT) else $error("blocked scan kept sync or run");
	chk_run_cause: assert property ($rose(SAFETY_OUTPUT_PAIR_OUT)
		|-> $past(SCAN_DONE_IN || START_IN)) else $error("run entered without scan or start");
	chk_nv_pulse: assert property (NV_WRITE_OUT |=> !NV_WRITE_OUT)
		else $error("store strobe longer than one cycle");
	chk_rdata_zero: assert property (CE_IN && !RD_IN |=> RDATA_OUT == 32'h00000000)
		else $error("read data outside read slot");
endmodule

bind beam_eval beam_eval_chk u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
	.BEAMS_BLOCKED_IN(BEAMS_BLOCKED_IN), .SCAN_DONE_IN(SCAN_DONE_IN), .START_IN(START_IN),
	.WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .NV_WRITE_OUT(NV_WRITE_OUT),
	.SAFETY_OUTPUT_PAIR_OUT(SAFETY_OUTPUT_PAIR_OUT), .INTERLOCK_OUT(INTERLOCK_OUT),
	.BLANK_ACTIVE_OUT(BLANK_ACTIVE_OUT), .SYNC_OUT(SYNC_OUT),
	.BEAM_INDICATOR_LAMP_OUT(BEAM_INDICATOR_LAMP_OUT));

/* File: verif/beam_source.sv */
// optical transmitter model: presents one scan frame of beam states
`timescale 1ns/100ps

module beam_source (
	input  wire logic        clk_in,
	input  wire logic [31:0] obj_in,
	input  wire logic        fire_in,
	output logic      [31:0] beams_out,
	output logic             scan_out
);
	// outside a frame the word flips so stale use shows up
	always_ff @(posedge clk_in) begin
		scan_out  <= fire_in;
		beams_out <= fire_in ? obj_in : ~beams_out;
	end
endmodule

/* File: verif/testbench.sv */
// self-checking testbench of the beam evaluation block
`timescale 1ns/100ps
`include "beam_eval_regs.svh"

module testbench;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] obj = 32'h0;
	logic        fire = 1'b0;
	logic [31:0] beams;
	logic        scan;
	logic        start = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        nv_valid = 1'b0;
	logic [31:0] nv_area = 32'h0;
	logic [5:0]  nv_size = 6'h0;
	logic        nv_wr, nvv_o, safe, ilock, blank, sync;
	logic [31:0] nva_o, lamps, d, m;
	logic [5:0]  nvs_o;
	logic [31:0] bad [5] = '{32'h0F, 32'h81, 32'h8E, 32'h4E, 32'h02};
	int          errors = 0;
	int          n_checks = 0;
	int          nv_pulses = 0;

	beam_source u_beam_source (.clk_in(clk), .obj_in(obj), .fire_in(fire), .beams_out(beams),
		.scan_out(scan));
	beam_eval u_beam_eval (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .BEAMS_BLOCKED_IN(beams),
		.SCAN_DONE_IN(scan), .START_IN(start), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
		.RD_IN(rd), .RDATA_OUT(rdata), .NV_VALID_IN(nv_valid), .NV_AREA_IN(nv_area),
		.NV_SIZE_IN(nv_size), .NV_WRITE_OUT(nv_wr), .NV_VALID_OUT(nvv_o), .NV_AREA_OUT(nva_o),
		.NV_SIZE_OUT(nvs_o), .SAFETY_OUTPUT_PAIR_OUT(safe), .INTERLOCK_OUT(ilock),
		.BLANK_ACTIVE_OUT(blank), .SYNC_OUT(sync), .BEAM_INDICATOR_LAMP_OUT(lamps));

	initial begin
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		if (nv_wr === 1'b1) nv_pulses++;
	end

	// ==========================================
	// access tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
		@(posedge clk); wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk); addr <= a; rd <= 1'b1;
		@(posedge clk); rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		rd_reg(a);
		chk(d, exp);
	endtask

	// frame handed to the source, taken by the design two edges later
	task automatic do_scan(input logic [31:0] b);
		@(posedge clk); obj <= b; fire <= 1'b1;
		@(posedge clk); fire <= 1'b0;
		@(posedge clk); #1;
	endtask

	task automatic push_start;
		@(posedge clk); start <= 1'b1;
		@(posedge clk); start <= 1'b0;
		#1;
	endtask

	// expected run, interlock, blank, sync
	task automatic st(input logic [3:0] e);
		chk({28'h0, safe, ilock, blank, sync}, {28'h0, e});
	endtask

	task test_done;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================
	// tests
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(`OFS_CTRL, 32'h0);
		rd_chk(`OFS_AREA, 32'h0);
		rd_chk(4'h1, 32'h0);
		$display("test factory done");
		do_scan(32'hFFFFFFFF); st(4'b0000); chk(lamps, 32'h55555555);
		do_scan(32'hFFFFFFC0); st(4'b0000);
		do_scan(32'hFFFFFF80); st(4'b0001); chk(lamps, 32'hFFFFFF80);
		do_scan(32'h0); st(4'b1001);
		wr_reg(`OFS_CMD, {29'h0, `CMD_RESTART});
		rd_chk(`OFS_STATUS, 32'h90);
		do_scan(32'h0000FFFF); st(4'b0001);
		$display("test sync done");
		for (int n = 1; n <= 3; n++) begin
			m = (32'h1 << n) - 32'h1;
			wr_reg(`OFS_CTRL, 32'h2 | (n << 2));
			do_scan(32'h0); st(4'b1011);
			do_scan(m << 8); st(4'b1011);
			do_scan(((m << 1) | 32'h1) << 8); st(4'b0001);
			chk(lamps, ((m << 1) | 32'h1) << 8);
		end
		foreach (bad[i]) begin
			wr_reg(`OFS_CTRL, bad[i]);
			rd_reg(`OFS_STATUS); chk({31'h0, d[11]}, 32'h1);
			rd_chk(`OFS_CTRL, 32'hE);
		end
		$display("test resolution done");
		for (int n = 0; n < 4; n++) begin
			wr_reg(`OFS_CTRL, 32'h6 | (n << 4));
			do_scan(32'hFFFFFFFF);
			do_scan(32'h00100000); st((n == 1 || n == 3) ? 4'b0111 : 4'b1011);
			push_start(); st(4'b1011);
		end
		$display("test modes done");
		wr_reg(`OFS_CTRL, 32'h0);
		wr_reg(`OFS_CTRL, 32'h1);
		do_scan(32'h00300000); wr_reg(`OFS_CMD, {29'h0, `CMD_BEGIN});
		do_scan(32'h00300000); do_scan(32'h00600000); do_scan(32'h00C00000);
		wr_reg(`OFS_CMD, {29'h0, `CMD_END});
		wr_reg(`OFS_CMD, {29'h0, `CMD_FINISH});
		rd_chk(`OFS_AREA, 32'h00F00000);
		rd_chk(`OFS_CMD, 32'h2);
		chk(nv_pulses, 32'h1); chk(nva_o, 32'h00F00000);
		chk({26'h0, nvs_o}, 32'h2);
		do_scan(32'h00C00000); st(4'b1011); push_start(); st(4'b1011);
		do_scan(32'h00E00000); st(4'b1011);
		do_scan(32'h00100000); st(4'b1011);
		do_scan(32'h00100020); st(4'b0001);
		do_scan(32'h0); st(4'b0001);
		$display("test teach done");
		@(posedge clk); nv_valid <= nvv_o; nv_area <= nva_o; nv_size <= nvs_o; rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(`OFS_AREA, 32'h00F00000);
		rd_chk(`OFS_CMD, 32'h2);
		wr_reg(`OFS_CTRL, 32'h0);
		rd_chk(`OFS_AREA, 32'h0);
		chk(nv_pulses, 32'h2); chk({31'h0, nvv_o}, 32'h0);
		$display("test recall done");
		// area that leaves no seven-beam clear run in the first segment
		wr_reg(`OFS_CTRL, 32'h1);
		do_scan(32'h00003FF0); wr_reg(`OFS_CMD, {29'h0, `CMD_BEGIN});
		do_scan(32'h00003FF0); wr_reg(`OFS_CMD, {29'h0, `CMD_END});
		wr_reg(`OFS_CMD, {29'h0, `CMD_FINISH});
		rd_chk(`OFS_STATUS, 32'h580);
		chk(nv_pulses, 32'h2); chk({31'h0, nvv_o}, 32'h0);
		$display("test refuse done");
		test_done();
	end

	initial begin
		#(50 * 5000);
		errors++;
		test_done();
	end
endmodule
